/* File: core/upsc_defs.vh */
// Purpose: constants for the usb port switch control block
// Assumes: plain verilog-2005, included by bare name
// Notes:   mode and path codes, reset values and id codes
//
// Overview of operation
// (R01) pull charger_attach_n low on charger attach, else release it
// (R02) interrupt output idles high, goes low to request a status read
// (R03) interrupt on change of id pin, bus power or attach status
// (R04) connector d+ goes to at most one of host1, host2 or right audio
// (R05) connector d- goes to at most one of host1, host2 or left audio
// (R06) reset comes up in manual switching mode, enable equals 1
// (R07) reset manual settings select host1 data and power switch closed
// (R08) manual host1 switches close only with accessory or valid power
// (R09) bus power switch closes only while bus power is valid
// (R10) with no accessory every signal and power switch stays open
// (R11) processor may write switch state, device applies it
// (R12) id pin detects accessory type and remote button presses
// (R13) usb accessories identified from standard id resistor
// (R14) soft reset bit, bit 6 of control at 02h, resets device
// (R15) soft reset spares control, manual switch and charge registers
// (R16) interrupt mask set after reset, must clear before interrupt
// (R17) interrupt released after processor reads the status
`ifndef UPSC_DEFS_VH
`define UPSC_DEFS_VH

// path selection codes for d+ and d-
`define UPSC_PATH_OPEN   2'h0
`define UPSC_PATH_HOST1  2'h1
`define UPSC_PATH_HOST2  2'h2
`define UPSC_PATH_AUDIO  2'h3

// id pin classification codes
`define UPSC_ID_FLOAT    2'h0
`define UPSC_ID_USB      2'h1
`define UPSC_ID_AUDIO    2'h2
`define UPSC_ID_OTHER    2'h3

// control register layout
`define UPSC_CTRL_ADDR   8'h02
`define UPSC_CTRL_SRST   6

// reset values
`define UPSC_RST_MAN_EN  1'b1
`define UPSC_RST_MAN_SW  2'h1
`define UPSC_RST_MAN_VB  1'b1
`define UPSC_RST_MASK    1'b1

`endif

/* File: core/upsc_ctrl.v */
// Purpose: digital control of a usb port accessory switch
// Assumes: i2c slave decodes writes; analog front end gives sampled levels
// Notes:   switch controls are one-hot enables, open when low
`timescale 1ns/1ps
`default_nettype none
`include "upsc_defs.vh"

module upsc_ctrl (
	// clock and reset
	input  wire       clk_i,
	input  wire       srst_i,
	// analog detection
	input  wire [1:0] connector_id_pin_i,
	input  wire       id_button_i,
	input  wire       vbus_valid_i,
	input  wire       charger_seen_i,
	// processor writes
	input  wire       reg_wr_i,
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       man_en_i,
	input  wire [1:0] man_path_i,
	input  wire       man_vbus_i,
	input  wire       man_wr_i,
	input  wire       mask_i,
	input  wire       mask_wr_i,
	input  wire [1:0] auto_path_i,
	input  wire       status_rd_i,
	// switch controls
	output reg        first_host_dplus_o,
	output reg        first_host_dminus_o,
	output reg        second_host_dplus_o,
	output reg        second_host_dminus_o,
	output reg        audio_right_o,
	output reg        audio_left_o,
	output reg        vbus_switch_o,
	// status and pins
	output reg        charger_attach_n_o,
	output reg        charger_attach_n_oe_o,
	output reg        host_irq_n_o,
	output reg        attached_o,
	output reg [1:0]  id_type_o,
	output reg        button_o,
	output reg        man_en_o,
	output reg        mask_o
);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	reg  [1:0] man_path_q;
	reg        man_vbus_q;
	reg  [1:0] last_id_q;
	reg        last_vb_q;
	reg        last_att_q;
	reg        soft_q;
	wire       soft_rst;
	wire       attach;
	wire       change;
	wire [1:0] path;

	assign soft_rst = reg_wr_i && (reg_addr_i == `UPSC_CTRL_ADDR) &&
		reg_wdata_i[`UPSC_CTRL_SRST]; // [R14]
	assign attach   = (connector_id_pin_i != `UPSC_ID_FLOAT) || vbus_valid_i;
	assign change   = (connector_id_pin_i != last_id_q) ||
		(vbus_valid_i != last_vb_q) || (attach != last_att_q); // [R03]
	assign path     = man_en_o ? man_path_q : auto_path_i; // [R11]

	// control and manual registers survive soft reset
	always @(posedge clk_i) begin
		if (srst_i) begin
			man_en_o   <= `UPSC_RST_MAN_EN; // [R06]
			man_path_q <= `UPSC_RST_MAN_SW; // [R07]
			man_vbus_q <= `UPSC_RST_MAN_VB; // [R07]
		end else if (man_wr_i) begin
			man_en_o   <= man_en_i; // [R11]
			man_path_q <= man_path_i;
			man_vbus_q <= man_vbus_i;
		end
	end

	// ----------------------------------------------------------------
	// status, detection and interrupt
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		soft_q <= soft_rst;
		// live pin state, so soft reset must not hide an attach [R10]
		attached_o <= srst_i ? 1'b0 : attach;
		if (srst_i || soft_q) begin // [R15]
			mask_o       <= `UPSC_RST_MASK; // [R16]
			host_irq_n_o <= 1'b1; // [R02]
			last_id_q    <= `UPSC_ID_FLOAT;
			last_vb_q    <= 1'b0;
			last_att_q   <= 1'b0;
			id_type_o    <= `UPSC_ID_FLOAT;
			button_o     <= 1'b0;
		end else begin
			if (mask_wr_i)
				mask_o <= mask_i;
			last_id_q  <= connector_id_pin_i;
			last_vb_q  <= vbus_valid_i;
			last_att_q <= attach;
			id_type_o  <= connector_id_pin_i; // [R12] [R13]
			button_o   <= id_button_i && (connector_id_pin_i ==
				`UPSC_ID_AUDIO); // [R12]
			// a change in the read cycle wins over the release
			if (change && !mask_o)
				host_irq_n_o <= 1'b0; // [R03] [R16]
			else if (status_rd_i)
				host_irq_n_o <= 1'b1; // [R17]
		end
	end

	// ----------------------------------------------------------------
	// switch matrix
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (srst_i) begin
			first_host_dplus_o    <= 1'b0;
			first_host_dminus_o   <= 1'b0;
			second_host_dplus_o   <= 1'b0;
			second_host_dminus_o  <= 1'b0;
			audio_right_o         <= 1'b0;
			audio_left_o          <= 1'b0;
			vbus_switch_o         <= 1'b0;
			charger_attach_n_o    <= 1'b0;
			charger_attach_n_oe_o <= 1'b0;
		end else begin
			// one-hot decode keeps each line on a single path
			first_host_dplus_o   <= attach && path == `UPSC_PATH_HOST1; // [R04] [R08] [R10]
			first_host_dminus_o  <= attach && path == `UPSC_PATH_HOST1; // [R05] [R08]
			second_host_dplus_o  <= attach && path == `UPSC_PATH_HOST2; // [R04] [R10]
			second_host_dminus_o <= attach && path == `UPSC_PATH_HOST2; // [R05]
			audio_right_o        <= attach && path == `UPSC_PATH_AUDIO; // [R04]
			audio_left_o         <= attach && path == `UPSC_PATH_AUDIO; // [R05]
			vbus_switch_o <= vbus_valid_i && (man_en_o ? man_vbus_q : 1'b1); // [R09]
			charger_attach_n_o    <= 1'b0;
			charger_attach_n_oe_o <= charger_seen_i && vbus_valid_i; // [R01]
		end
	end

endmodule
`default_nettype wire

/* File: test/upsc_pull.sv */
// Purpose: charger pin as seen on the board
// Assumes: open-drain output with a pull-up
// Notes:   a released pin reads high, never the last value
`timescale 1ns/1ps
`default_nettype none
module upsc_pull (
	input  wire logic oe_i,
	output wire logic pin_o
);
	assign pin_o = oe_i ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

/* File: test/upsc_ctrl_monitor.sv */
// Purpose: port checker for upsc_ctrl
// Assumes: outputs follow inputs one edge later
// Notes:   attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module upsc_mon (
	input wire logic clk_i, srst_i, vbus_valid_i, charger_seen_i, man_wr_i,
	input wire logic man_en_i, reg_wr_i, first_host_dplus_o, audio_right_o,
	input wire logic second_host_dplus_o, vbus_switch_o, attached_o, mask_o,
	input wire logic charger_attach_n_o, charger_attach_n_oe_o, man_en_o,
	input wire logic host_irq_n_o,
	input wire logic first_host_dminus_o,
	input wire logic second_host_dminus_o,
	input wire logic audio_left_o,
	input wire logic [1:0] connector_id_pin_i,
	input wire logic [7:0] reg_addr_i, reg_wdata_i);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_dplus_one: assert property (
		$onehot0({first_host_dplus_o, second_host_dplus_o, audio_right_o}))
		else $error("dplus on two paths");
	a_dminus_one: assert property (
		$onehot0({first_host_dminus_o, second_host_dminus_o, audio_left_o}))
		else $error("dminus on two paths");
	a_idle_open: assert property (!attached_o |-> !(vbus_switch_o |
		first_host_dplus_o | second_host_dplus_o | audio_right_o))
		else $error("switch closed while detached");
	a_host_cause: assert property (first_host_dplus_o |->
		$past(connector_id_pin_i != 2'h0 || vbus_valid_i))
		else $error("host1 closed with nothing attached");
	a_vbus_valid: assert property (vbus_switch_o |-> $past(vbus_valid_i))
		else $error("power switch closed without bus power");
	a_charge_pull: assert property (charger_attach_n_oe_o |->
		!charger_attach_n_o && $past(charger_seen_i && vbus_valid_i))
		else $error("charger pin pulled without charger");
	a_mask_quiet: assert property ($fell(host_irq_n_o) |-> !$past(mask_o))
		else $error("interrupt while masked");
	a_irq_raise: assert property (
		$changed(vbus_valid_i) && !mask_o |-> ##[1:2] !host_irq_n_o)
		else $error("no interrupt on bus power change");
	a_manual_load: assert property (
		man_wr_i |=> man_en_o == $past(man_en_i))
		else $error("manual enable not applied");
	a_soft_keep: assert property (
		reg_wr_i && reg_addr_i == 8'h02 && reg_wdata_i[6] |->
		##3 mask_o && man_en_o == $past(man_en_o, 3))
		else $error("soft reset wrong");
endmodule
bind upsc_ctrl upsc_mon mon (.*);
`default_nettype wire

/* File: test/tb_usb_port_switch_control.sv */
// Purpose: directed bench for upsc_ctrl
// Assumes: 10 MHz clock, reset held three cycles
// Notes:   checks wait three edges for registered outputs
`timescale 1ns/1ps
`default_nettype none
module tb_usb_port_switch_control;
	logic clk_i = 0, srst_i = 1, id_button_i = 0, vbus_valid_i = 0, chg_pin;
	logic charger_seen_i = 0, reg_wr_i = 0, man_en_i = 0, man_vbus_i = 0;
	logic man_wr_i = 0, mask_i = 0, mask_wr_i = 0, status_rd_i = 0;
	logic [1:0] connector_id_pin_i = 0, man_path_i = 0, auto_path_i = 0;
	logic [7:0] reg_addr_i = 0, reg_wdata_i = 0;
	logic first_host_dplus_o, first_host_dminus_o, second_host_dplus_o;
	logic second_host_dminus_o, audio_right_o, audio_left_o, vbus_switch_o;
	logic charger_attach_n_o, charger_attach_n_oe_o, host_irq_n_o;
	logic attached_o, button_o, man_en_o, mask_o;
	logic [1:0] id_type_o;
	int err_total = 0, total_checks = 0, cyc = 0;
	upsc_ctrl dut (.*);
	upsc_pull pull (.oe_i(charger_attach_n_oe_o), .pin_o(chg_pin));
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc > 500) begin
		err_total++;
		complete_run;
	end
	task ck(string n, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task tick(int n); repeat (n) @(posedge clk_i); endtask
	task complete_run;
		$display("errors %0d checks %0d", err_total, total_checks);
		if (err_total == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		tick(3); srst_i <= 0; tick(3);
		ck("en mask irq", 8'h7, {man_en_o, mask_o, host_irq_n_o});
		ck("open", 8'h0, {first_host_dplus_o, vbus_switch_o});
		connector_id_pin_i <= 1; tick(3);
		ck("id only", 8'h2, {first_host_dplus_o, vbus_switch_o});
		connector_id_pin_i <= 0; vbus_valid_i <= 1; tick(3);
		ck("host1", 8'hf, {first_host_dplus_o, first_host_dminus_o,
			vbus_switch_o, host_irq_n_o});
		mask_wr_i <= 1; tick(1); mask_wr_i <= 0; vbus_valid_i <= 0; tick(3);
		ck("irq", 8'h0, host_irq_n_o);
		status_rd_i <= 1; tick(1); status_rd_i <= 0; tick(2);
		ck("irq", 8'h1, host_irq_n_o);
		vbus_valid_i <= 1; charger_seen_i <= 1; tick(3);
		ck("chg pin", 8'h0, chg_pin);
		man_en_i <= 1; man_path_i <= 2; man_wr_i <= 1; tick(1); man_wr_i <= 0; tick(2);
		ck("host2", 8'h18, {second_host_dplus_o, second_host_dminus_o,
			first_host_dplus_o, audio_right_o, vbus_switch_o});
		man_en_i <= 0; auto_path_i <= 3; man_wr_i <= 1; tick(1); man_wr_i <= 0; tick(2);
		ck("audio", 8'h6, {audio_right_o, audio_left_o, first_host_dplus_o});
		reg_addr_i <= 8'h02; reg_wdata_i <= 8'h40; reg_wr_i <= 1; tick(1);
		reg_wr_i <= 0; tick(3);
		ck("soft reset", 8'h2, {mask_o, man_en_o});
		connector_id_pin_i <= 2; id_button_i <= 1; tick(3);
		ck("button", 8'he, {attached_o, button_o, id_type_o});
		complete_run;
	end
endmodule
`default_nettype wire
